// *** design/fae_fault_alert_engine.v ***
/*
 fault alert engine: records fault events as a last code and per-bit flags and
 drives the fault alert pin in legacy code-mask or per-bit mode; AHB-Lite slave.
 assumes single 32-bit word transfers from the one master; fault inputs are
 one-cycle pulses synchronous to clk; at most one code is kept per cycle.
*/
//
// Function
// [RULE1] legacy code-mask mode when legacy mask non-zero, else per-bit flag mode
// [RULE2] legacy: pin sets on fault whose code AND legacy mask is non-zero
// [RULE3] legacy: pin clears only when host reads the last fault code register
// [RULE4] legacy: nothing else, including mask writes, changes the pin
// [RULE5] a new fault overwrites the stored code, keeping only the latest
// [RULE6] inbound overflow records 0x08, outbound overflow records 0x09
// [RULE7] failed register write records 0x13
// [RULE8] missing acknowledgement after maximum retries records 0x20
// [RULE9] payload crc fault records 0x40, header crc fault records 0x42
// [RULE10] bad ack sequence identifier records 0x43
// [RULE11] invalid network mode or bad frame type records 0x44
// [RULE12] mask 0x08 passes only overflows, 0x10 only register write fault
// [RULE13] mask 0x40 packet errors, 0x60 adds missing ack, 0xff passes all
// [RULE14] legacy mask gates only the pin; code is always stored
// [RULE15] storing a code also sets its per-bit fault flag
// [RULE16] per-bit: pin high exactly while flags AND per-bit mask non-zero
// [RULE17] flag or mask writes update the pin; other unmasked flags keep it set
// [RULE18] pin state mirrored in readable line state word
// [RULE19] host should prefer per-bit mode, the reset default
// [RULE20] host may poll alert or registers after buffer empty line goes high
// [RULE21] reset clears code and flags and deasserts the pin
`timescale 1ns/10ps
`include "fae_regs.vh"
module fae_fault_alert_engine (
  // clock and reset
  input  wire        clk,
  input  wire        nrst,
  // ahb-lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire        hready,
  input  wire [31:0] hwdata,
  output reg  [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  // fault event pulses
  input  wire        inboundUartOverflow,
  input  wire        outboundUartOverflow,
  input  wire        registerWriteFault,
  input  wire        missingAckFault,
  input  wire        payloadCrcFault,
  input  wire        headerCrcFault,
  input  wire        ackSequenceFault,
  input  wire        frameTypeFault,
  // buffer state for line state word
  input  wire        bufferEmptyLine,
  // alert pin
  output reg         faultAlertPin
);

  reg  [7:0] legacyAlertMask;
  reg  [7:0] lastFaultCode;
  reg  [7:0] perBitFaultFlags;
  reg  [7:0] perBitAlertMask;
  reg        dpWrite;
  reg        dpRead;
  reg  [7:0] dpAddr;
  reg  [7:0] faultCode;
  reg  [7:0] faultBits;
  reg  [7:0] next_flags;
  reg        next_pin;
  reg  [31:0] next_rdata;
  wire [7:0] faultIn;
  wire       faultAny;
  wire       apValid;
  wire       codeRead;
  wire       legacyMode;

  // encode one code per cycle; the order gives priority to packet faults
  function [7:0] faeCodeOf;
    input [7:0] f;
    begin
      if (f[`FAE_BIT_FRAME_TYPE])
        faeCodeOf = `FAE_CODE_FRAME_TYPE; // [RULE11]
      else if (f[`FAE_BIT_ACK_SEQ])
        faeCodeOf = `FAE_CODE_ACK_SEQ; // [RULE10]
      else if (f[`FAE_BIT_HEADER_CRC])
        faeCodeOf = `FAE_CODE_HEADER_CRC; // [RULE9]
      else if (f[`FAE_BIT_PAYLOAD_CRC])
        faeCodeOf = `FAE_CODE_PAYLOAD_CRC; // [RULE9]
      else if (f[`FAE_BIT_NO_ACK])
        faeCodeOf = `FAE_CODE_NO_ACK; // [RULE8]
      else if (f[`FAE_BIT_WREG_FAIL])
        faeCodeOf = `FAE_CODE_WREG_FAIL; // [RULE7]
      else if (f[`FAE_BIT_OUTB_OVFL])
        faeCodeOf = `FAE_CODE_OUTB_OVFL; // [RULE6]
      else if (f[`FAE_BIT_INB_OVFL])
        faeCodeOf = `FAE_CODE_INB_OVFL; // [RULE6]
      else
        faeCodeOf = `FAE_CODE_NONE;
    end
  endfunction

  // flag bit that belongs to a code
  function [7:0] faeBitOf;
    input [7:0] c;
    begin
      faeBitOf = 8'h00;
      case (c)
        `FAE_CODE_INB_OVFL:    faeBitOf[`FAE_BIT_INB_OVFL] = 1'b1;
        `FAE_CODE_OUTB_OVFL:   faeBitOf[`FAE_BIT_OUTB_OVFL] = 1'b1;
        `FAE_CODE_WREG_FAIL:   faeBitOf[`FAE_BIT_WREG_FAIL] = 1'b1;
        `FAE_CODE_NO_ACK:      faeBitOf[`FAE_BIT_NO_ACK] = 1'b1;
        `FAE_CODE_PAYLOAD_CRC: faeBitOf[`FAE_BIT_PAYLOAD_CRC] = 1'b1;
        `FAE_CODE_HEADER_CRC:  faeBitOf[`FAE_BIT_HEADER_CRC] = 1'b1;
        `FAE_CODE_ACK_SEQ:     faeBitOf[`FAE_BIT_ACK_SEQ] = 1'b1;
        `FAE_CODE_FRAME_TYPE:  faeBitOf[`FAE_BIT_FRAME_TYPE] = 1'b1;
        default:               faeBitOf = 8'h00;
      endcase
    end
  endfunction

  assign faultIn = {frameTypeFault, ackSequenceFault, headerCrcFault, payloadCrcFault,
                    missingAckFault, registerWriteFault, outboundUartOverflow,
                    inboundUartOverflow};
  assign faultAny = |faultIn;
  assign hreadyout = 1'b1;
  assign hresp = `FAE_HRESP_OKAY;
  assign apValid = hsel & hready & (htrans == `FAE_HTRANS_NONSEQ);
  assign codeRead = dpRead & (dpAddr == `FAE_OFF_LAST_CODE);
  assign legacyMode = |legacyAlertMask; // [RULE1]

  always @*
  begin
    faultCode = faeCodeOf(faultIn);
    faultBits = faeBitOf(faultCode); // [RULE15]
  end

  // flag update: software writes, then hardware sets win over clears
  always @*
  begin
    next_flags = perBitFaultFlags;
    if (dpWrite && dpAddr == `FAE_OFF_FLAGS)
      next_flags = hwdata[7:0];
    else if (dpWrite && dpAddr == `FAE_OFF_FLAG_CLEAR)
      next_flags = perBitFaultFlags & ~hwdata[7:0];
    next_flags = next_flags | faultBits; // [RULE15]
  end

  // alert pin next value
  always @*
  begin
    next_pin = faultAlertPin;
    if (legacyMode)
    begin
      if (faultAny && ((faultCode & legacyAlertMask) != 8'h00))
        next_pin = 1'b1; // [RULE2] [RULE12] [RULE13]
      else if (codeRead)
        next_pin = 1'b0; // [RULE3] [RULE4]
    end
    else
      next_pin = ((perBitFaultFlags & perBitAlertMask) != 8'h00); // [RULE16] [RULE17]
  end

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      dpWrite <= 1'b0;
      dpRead <= 1'b0;
      dpAddr <= 8'h00;
    end
    else
    begin
      dpWrite <= apValid & hwrite;
      dpRead <= apValid & ~hwrite;
      dpAddr <= haddr[7:0] & `FAE_OFF_MASK;
    end
  end

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      legacyAlertMask <= `FAE_LMASK_RST;
      perBitAlertMask <= `FAE_BMASK_RST;
      lastFaultCode <= `FAE_CODE_NONE; // [RULE21]
      perBitFaultFlags <= `FAE_FLAGS_RST; // [RULE21]
      faultAlertPin <= 1'b0; // [RULE21]
    end
    else
    begin
      if (dpWrite && dpAddr == `FAE_OFF_LEGACY_MASK)
        legacyAlertMask <= hwdata[7:0]; // [RULE4]
      if (dpWrite && dpAddr == `FAE_OFF_BIT_MASK)
        perBitAlertMask <= hwdata[7:0]; // [RULE17]
      if (faultAny)
        lastFaultCode <= faultCode; // [RULE5] [RULE14]
      perBitFaultFlags <= next_flags;
      faultAlertPin <= next_pin;
    end
  end

  // read data for the address phase being accepted
  always @*
  begin
    next_rdata = 32'h00000000;
    case (haddr[7:0] & `FAE_OFF_MASK)
      `FAE_OFF_LEGACY_MASK: next_rdata[7:0] = legacyAlertMask;
      `FAE_OFF_LAST_CODE:   next_rdata[7:0] = lastFaultCode;
      `FAE_OFF_FLAGS:       next_rdata[7:0] = perBitFaultFlags;
      `FAE_OFF_BIT_MASK:    next_rdata[7:0] = perBitAlertMask;
      `FAE_OFF_LINE_STATE:
      begin
        next_rdata[`FAE_LS_ALERT] = faultAlertPin; // [RULE18]
        next_rdata[`FAE_LS_BUF_EMPTY] = bufferEmptyLine;
      end
      default:              next_rdata = 32'h00000000;
    endcase
  end

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      hrdata <= 32'h00000000;
    else if (apValid && !hwrite)
      hrdata <= next_rdata;
  end

endmodule

// *** design/fae_regs.vh ***
/*
 fault alert engine constants: register byte offsets, fault codes, field widths.
 assumes inclusion by the single design file; definitions only.
*/
`ifndef FAE_REGS_VH
`define FAE_REGS_VH
`define FAE_OFF_LEGACY_MASK   8'h00
`define FAE_OFF_LAST_CODE     8'h04
`define FAE_OFF_FLAGS         8'h08
`define FAE_OFF_BIT_MASK      8'h0c
`define FAE_OFF_LINE_STATE    8'h10
`define FAE_OFF_FLAG_CLEAR    8'h14
`define FAE_OFF_MASK          8'h1f
`define FAE_CODE_INB_OVFL     8'h08
`define FAE_CODE_OUTB_OVFL    8'h09
`define FAE_CODE_WREG_FAIL    8'h13
`define FAE_CODE_NO_ACK       8'h20
`define FAE_CODE_PAYLOAD_CRC  8'h40
`define FAE_CODE_HEADER_CRC   8'h42
`define FAE_CODE_ACK_SEQ      8'h43
`define FAE_CODE_FRAME_TYPE   8'h44
`define FAE_CODE_NONE         8'h00
`define FAE_NFLT              8
`define FAE_FLAGS_RST         8'h00
`define FAE_LMASK_RST         8'h00
`define FAE_BMASK_RST         8'hff
`define FAE_BIT_INB_OVFL      0
`define FAE_BIT_OUTB_OVFL     1
`define FAE_BIT_WREG_FAIL     2
`define FAE_BIT_NO_ACK        3
`define FAE_BIT_PAYLOAD_CRC   4
`define FAE_BIT_HEADER_CRC    5
`define FAE_BIT_ACK_SEQ       6
`define FAE_BIT_FRAME_TYPE    7
`define FAE_LS_ALERT          0
`define FAE_LS_BUF_EMPTY      1
`define FAE_HTRANS_NONSEQ     2'b10
`define FAE_HRESP_OKAY        1'b0
`endif

// *** dv/fae_fault_alert_engine_bench.sv ***
/* self-checking bench for the fault alert engine.
 assumes the host model drives the bus and hreadyout is fed back as hready. */
`timescale 1ns/10ps
module fae_fault_alert_engine_bench;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        bufE = 1'b1;
  logic        rp = 1'b0;
  logic [7:0]  flt = 8'h00;
  logic        hsel, hwrite, hreadyout, hresp, pin;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] expQ[$];
  logic [7:0]  codes[8] = '{8'h08, 8'h09, 8'h13, 8'h20, 8'h40, 8'h42, 8'h43, 8'h44};
  logic [7:0]  masks[5] = '{8'h08, 8'h10, 8'h40, 8'h60, 8'hff};
  int          n_errors = 0;
  int          comparisons = 0;
  always #12.5 clk = ~clk;
  fae_host_model host_u (.clk, .nrst, .hready(hreadyout), .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata);
  fae_fault_alert_engine dut_u (.clk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .inboundUartOverflow(flt[0]),
    .outboundUartOverflow(flt[1]), .registerWriteFault(flt[2]), .missingAckFault(flt[3]),
    .payloadCrcFault(flt[4]), .headerCrcFault(flt[5]), .ackSequenceFault(flt[6]),
    .frameTypeFault(flt[7]), .bufferEmptyLine(bufE), .faultAlertPin(pin));
  // read data phase: compare against the oldest note
  always @(posedge clk)
  begin
    if (rp)
    begin
      comparisons++;
      if (expQ.size() == 0 || hrdata !== expQ.pop_front())
      begin
        n_errors++;
        $display("BAD %0t read data %h", $time, hrdata);
      end
    end
    if (nrst && (hreadyout !== 1'b1 || hresp !== 1'b0))
    begin
      n_errors++;
      $display("BAD %0t bus response not ready okay", $time);
    end
    rp = nrst && hsel && hreadyout && htrans == 2'b10 && !hwrite;
  end
  // direct look at the alert pin, settled after the edge
  task chk(input logic e);
    #1;
    comparisons++;
    if (pin !== e)
    begin
      n_errors++;
      $display("BAD %0t alert pin %b", $time, pin);
    end
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    expQ.push_back(e);
    host_u.xfer(1'b0, a, 32'h0);
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    host_u.xfer(1'b1, a, {24'h0, d});
  endtask
  task fault(input int i);
    @(posedge clk);
    flt <= 8'h01 << i;
    @(posedge clk);
    flt <= 8'h00;
  endtask
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    $display("BAD %0t timeout", $time);
    tally_and_finish;
  end
  initial
  begin
    logic [7:0] f;
    logic       b;
    int         i;
    void'($urandom(32'he685));
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    rd(8'h08, 32'h0);
    rd(8'h0c, 32'hff);
    rd(8'h18, 32'h0);
    rd(8'h10, 32'h2);
    $display("test reset done");
    f = 8'h00;
    for (i = 0; i < 8; i++)
    begin
      fault(i);
      f[i] = 1'b1;
      rd(8'h04, codes[i]);
      rd(8'h08, f);
    end
    rd(8'h10, 32'h3);
    chk(1'b1);
    wr(8'h08, 8'h03);
    wr(8'h08, 8'h02);
    rd(8'h10, 32'h3);
    wr(8'h08, 8'h00);
    rd(8'h10, 32'h2);
    chk(1'b0);
    $display("test per-bit done");
    foreach (masks[j])
      for (int k = 0; k < 2; k++)
      begin
        i = k ? $urandom % 8 : 0;
        b = $urandom;
        bufE <= b;
        wr(8'h00, masks[j]);
        fault(i);
        wr(8'h00, masks[j]);
        rd(8'h10, {b, |(codes[i] & masks[j])});
        rd(8'h04, codes[i]);
        rd(8'h10, {b, 1'b0});
        chk(1'b0);
      end
    // host returns to the per-bit default mode
    wr(8'h00, 8'h00);
    $display("test legacy done");
    tally_and_finish;
  end
endmodule

// *** dv/fae_fault_alert_engine_properties.sv ***
/* alert pin checker bound to the engine.
 assumes the per-bit mask stays at its reset value 0xff. */
`timescale 1ns/10ps
module fae_alert_checker (
  input wire logic clk, nrst, hsel, hwrite, hready, bufferEmptyLine, faultAlertPin,
  input wire logic [31:0] haddr, hwdata, hrdata,
  input wire logic [1:0] htrans,
  input wire logic inboundUartOverflow, outboundUartOverflow, registerWriteFault,
  input wire logic missingAckFault, payloadCrcFault, headerCrcFault, ackSequenceFault,
  input wire logic frameTypeFault
);
  logic [7:0] lm, wa;
  logic       wv, rc, rl;
  wire anyF = inboundUartOverflow | outboundUartOverflow | registerWriteFault |
    missingAckFault | payloadCrcFault | headerCrcFault | ackSequenceFault | frameTypeFault;
  wire take = hsel && hready && htrans == 2'b10;
  // shadow of the legacy mask and the data phase kind
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      wv <= 1'b0;
      rc <= 1'b0;
      rl <= 1'b0;
      wa <= 8'h00;
      lm <= 8'h00;
    end
    else
    begin
      wv <= take && hwrite;
      rc <= take && !hwrite && haddr[7:0] == 8'h04;
      rl <= take && !hwrite && haddr[7:0] == 8'h10;
      wa <= haddr[7:0];
      if (wv && wa == 8'h00)
        lm <= hwdata[7:0];
    end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_pbSet; lm == 8'h00 && !wv && frameTypeFault ##1 !wv; endsequence
  sequence s_flagsZero;
    wv && wa == 8'h08 && hwdata[7:0] == 8'h00 && lm == 8'h00 && !anyF ##1 !anyF && !wv;
  endsequence
  a_reset_quiet: assert property ($rose(nrst) |-> !faultAlertPin)
    else $error("alert high after reset");
  a_legacy_set: assert property (lm != 8'h00 && !wv && (inboundUartOverflow && lm[3] ||
    frameTypeFault && lm[6]) |=> faultAlertPin) else $error("legacy alert not set");
  a_legacy_hold: assert property (lm != 8'h00 && faultAlertPin && !rc |=> faultAlertPin)
    else $error("legacy alert dropped");
  a_legacy_clear: assert property (lm != 8'h00 && rc && !anyF |=> !faultAlertPin)
    else $error("legacy alert not cleared");
  a_legacy_quiet: assert property (lm != 8'h00 && !faultAlertPin && !anyF |=> !faultAlertPin)
    else $error("legacy alert rose alone");
  a_perbit_set: assert property (s_pbSet |=> faultAlertPin)
    else $error("per-bit alert not set");
  a_perbit_clear: assert property (s_flagsZero |=> !faultAlertPin)
    else $error("per-bit alert not cleared");
  a_line_mirror: assert property (rl |-> hrdata[1:0] ==
    {$past(bufferEmptyLine), $past(faultAlertPin)}) else $error("line state wrong");
endmodule
bind fae_fault_alert_engine fae_alert_checker chk_u (.*);

// *** dv/fae_host_model.sv ***
/* host model: ahb-lite master making single word transfers.
 assumes the slave's hreadyout is the bus hready; the bench calls xfer. */
`timescale 1ns/10ps
module fae_host_model (
  // clock, reset and bus ready
  input  wire         clk,
  input  wire         nrst,
  input  wire         hready,
  // ahb-lite master outputs
  output logic        hsel,
  output logic [31:0] haddr,
  output logic [1:0]  htrans,
  output logic        hwrite,
  output logic [2:0]  hsize,
  output logic [31:0] hwdata
);
  initial
  begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // code reads issued here are what clears a legacy alert
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clk); while (!hready && ++n < 99);
    htrans <= 2'b00;
    haddr <= ~haddr;
    hwdata <= d;
    do @(posedge clk); while (!hready && ++n < 99);
    hwdata <= ~d;
  endtask
endmodule
